// ### pkg/cgcr_defs.svh
// Register offsets, bit positions, reset values and timing counts of the clock control block.
`ifndef CGCR_DEFS_SVH
`define CGCR_DEFS_SVH

`define CGCR_ADDR_SYS_CLK_CTRL 4'h0
`define CGCR_ADDR_LOW_PWR_CTRL 4'h1

`define CGCR_SYS_CLK_CTRL_RST 8'h00
`define CGCR_LOW_PWR_CTRL_RST 8'h00
`define CGCR_SYS_CLK_CTRL_WMASK 8'h8f

`define CGCR_BIT_SYSCLK_OUT_DISABLE 7
`define CGCR_BIT_MULT_SWITCH_MODE 3
`define CGCR_BIT_BUS_MASTER_CLK_SEL_HI 2
`define CGCR_BIT_BUS_MASTER_CLK_SEL_LO 0

`define CGCR_BIT_DIRECT_TRANSITION_ON 7
`define CGCR_BIT_LOW_SPEED_ON 6
`define CGCR_BIT_SUBCLK_GEN_STOP 4
`define CGCR_BIT_FEEDBACK_RES_CUT 3
`define CGCR_BIT_PLL_MULT_HI 1
`define CGCR_BIT_PLL_MULT_LO 0

`define CGCR_CLK_PERIOD_NS 25
`define CGCR_WAIT_UNIT_NS 400
`define CGCR_WAIT_UNIT_CYC ((`CGCR_WAIT_UNIT_NS + `CGCR_CLK_PERIOD_NS - 1) / `CGCR_CLK_PERIOD_NS)
`define CGCR_SUBCLK_HALF_LAST 6'h3f

`endif

// ### pkg/cgcr_pkg.sv
// Types shared by the clock control block.
package cgcr_pkg;

    typedef enum logic [3:0] {
        MODE_HIGH_SPEED = 4'h0,
        MODE_MED_SPEED = 4'h1,
        MODE_SUBACTIVE = 4'h2,
        MODE_SLEEP = 4'h3,
        MODE_SUBSLEEP = 4'h4,
        MODE_SW_STANDBY = 4'h5,
        MODE_WATCH = 4'h6,
        MODE_DIRECT_TRANS = 4'h7,
        MODE_HW_STANDBY = 4'h8
    } cgcr_mode_t;

    typedef enum logic [1:0] {
        ST_RUN = 2'h0,
        ST_STANDBY = 2'h1,
        ST_WAKE = 2'h2
    } cgcr_state_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } cgcr_bus_t;

    typedef struct packed {
        logic level;
        logic oe;
    } cgcr_pin_t;

endpackage

// ### core/cgcr_ctrl.sv
// Clock pulse generator control registers and the clock selection logic they steer.
//
// Function
// RULE1 - In running modes the clock pin carries the system clock unless output disable; the code drives a half-rate image of it.
// RULE2 - Standby, watch, direct transition hold pin high; hardware standby floats it.
// RULE3 - Three reserved bits of system clock register read zero and ignore writes.
// RULE4 - Switch mode zero: new multiplier applies only on entering software standby.
// RULE5 - Switch mode one: new multiplier applies right after the multiplier bits are written.
// RULE6 - Bus master clock is full speed or system clock divided by 2 to 32.
// RULE7 - Software writes zero into low power register bits 5 and 2.
// RULE8 - Subclock runs while its stop bit is zero and halts when one.
// RULE9 - Feedback cut clear: resistance on while oscillating, off while stopped.
// RULE10 - Feedback cut set: resistance off, effective at software standby entry or exit.
// RULE11 - Multiplier field selects one, two or four; code three is prohibited.
// RULE12 - On standby exit, wait the selected transition time before resuming.
// RULE13 - Subclock is the oscillator clock divided by 128.
// RULE14 - Direct transition and low speed bits are plain storage sent to power control.
// RULE15 - Reset clears all implemented bits of both registers.
//
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/1ps
`include "cgcr_defs.svh"

module cgcr_ctrl (
    input wire logic CORE_CLK_I,
    input wire logic RST_I,
    input wire logic [3:0] REG_ADDR_I,
    input wire logic [7:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    output logic [7:0] REG_RDATA_O,
    input wire logic [3:0] OP_MODE_I,
    input wire logic [2:0] STANDBY_WAIT_SEL_I,
    input wire logic OSC_TICK_I,
    output logic SYSCLK_OUT_O,
    output logic SYSCLK_OUT_OE_O,
    output logic BUS_MASTER_CLK_EN_O,
    output logic SUBCLK_O,
    output logic FEEDBACK_RES_ON_O,
    output logic [1:0] PLL_MULT_O,
    output logic CLK_RESUME_O,
    output logic DIRECT_TRANSITION_ON_O,
    output logic LOW_SPEED_ON_O
);

    // Mask of the bus master divider counter; prohibited codes fall back to full speed.
    function automatic logic [4:0] bm_mask(input logic [2:0] sel);
        case (sel)
            3'h1: bm_mask = 5'h01;
            3'h2: bm_mask = 5'h03;
            3'h3: bm_mask = 5'h07;
            3'h4: bm_mask = 5'h0f;
            3'h5: bm_mask = 5'h1f;
            default: bm_mask = 5'h00;
        endcase
    endfunction

    // Wake wait in cycles minus one: a base unit doubled for each step of the setting.
    function automatic logic [11:0] wake_cycles(input logic [2:0] sel);
        logic [11:0] unit;
        unit = 12'(`CGCR_WAIT_UNIT_CYC);
        wake_cycles = 12'((unit << sel) - 12'h001);
    endfunction

    cgcr_pkg::cgcr_bus_t bus;
    cgcr_pkg::cgcr_mode_t mode;
    cgcr_pkg::cgcr_state_t state_ff, nxt_state;
    cgcr_pkg::cgcr_pin_t pin_ff, nxt_pin;
    logic [7:0] sys_clk_ctrl_reg_ff, nxt_sys_clk_ctrl_reg;
    logic [7:0] low_power_ctrl_reg_ff, nxt_low_power_ctrl_reg;
    logic [7:0] rdata_ff, nxt_rdata;
    logic [1:0] mult_ff, nxt_mult;
    logic cut_ff, nxt_cut;
    logic [11:0] wait_ff, nxt_wait;
    logic phi_ff, nxt_phi;
    logic [4:0] bm_cnt_ff, nxt_bm_cnt;
    logic bm_en_ff, nxt_bm_en;
    logic [5:0] osc_cnt_ff, nxt_osc_cnt;
    logic subclk_ff, nxt_subclk;
    logic fb_on_ff, nxt_fb_on;
    logic wr_sck, wr_lpw, run_mode, stby_mode, osc_on;
    logic sysclk_out_disable, mult_switch_mode, subclk_gen_stop;
    logic [2:0] bm_sel;

    assign bus = '{addr: REG_ADDR_I, wdata: REG_WDATA_I, wr: REG_WR_I, rd: REG_RD_I};
    assign mode = cgcr_pkg::cgcr_mode_t'(OP_MODE_I);
    assign wr_sck = bus.wr && (bus.addr == `CGCR_ADDR_SYS_CLK_CTRL);
    assign wr_lpw = bus.wr && (bus.addr == `CGCR_ADDR_LOW_PWR_CTRL);
    assign sysclk_out_disable = sys_clk_ctrl_reg_ff[`CGCR_BIT_SYSCLK_OUT_DISABLE];
    assign mult_switch_mode = sys_clk_ctrl_reg_ff[`CGCR_BIT_MULT_SWITCH_MODE];
    assign bm_sel = sys_clk_ctrl_reg_ff[`CGCR_BIT_BUS_MASTER_CLK_SEL_HI:
                                        `CGCR_BIT_BUS_MASTER_CLK_SEL_LO];
    assign subclk_gen_stop = low_power_ctrl_reg_ff[`CGCR_BIT_SUBCLK_GEN_STOP];
    assign stby_mode = (mode == cgcr_pkg::MODE_SW_STANDBY) || (mode == cgcr_pkg::MODE_WATCH) ||
                       (mode == cgcr_pkg::MODE_DIRECT_TRANS);
    assign run_mode = !stby_mode && (mode != cgcr_pkg::MODE_HW_STANDBY);
    // The main oscillator is stopped in every standby state and until the wake wait ends.
    assign osc_on = run_mode && (state_ff == cgcr_pkg::ST_RUN);

    // Register file and read port.
    always_comb begin
        nxt_sys_clk_ctrl_reg = sys_clk_ctrl_reg_ff;
        nxt_low_power_ctrl_reg = low_power_ctrl_reg_ff;
        nxt_rdata = 8'h00;
        // RULE3 reserved bits masked
        if (wr_sck) begin
            nxt_sys_clk_ctrl_reg = bus.wdata & `CGCR_SYS_CLK_CTRL_WMASK;
        end
        // RULE14 plain storage bits
        if (wr_lpw) begin
            nxt_low_power_ctrl_reg = bus.wdata;
        end
        if (bus.rd) begin
            case (bus.addr)
                `CGCR_ADDR_SYS_CLK_CTRL: nxt_rdata = sys_clk_ctrl_reg_ff;
                `CGCR_ADDR_LOW_PWR_CTRL: nxt_rdata = low_power_ctrl_reg_ff;
                default: nxt_rdata = 8'h00;
            endcase
        end
    end

    // RULE15 reset to zero
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            sys_clk_ctrl_reg_ff <= `CGCR_SYS_CLK_CTRL_RST;
            low_power_ctrl_reg_ff <= `CGCR_LOW_PWR_CTRL_RST;
            rdata_ff <= 8'h00;
        end else begin
            sys_clk_ctrl_reg_ff <= nxt_sys_clk_ctrl_reg;
            low_power_ctrl_reg_ff <= nxt_low_power_ctrl_reg;
            rdata_ff <= nxt_rdata;
        end
    end

    // Standby sequencing, active multiplier and active feedback cut.
    always_comb begin
        nxt_state = state_ff;
        nxt_mult = mult_ff;
        nxt_cut = cut_ff;
        nxt_wait = wait_ff;
        // RULE5 immediate switch
        if (wr_lpw && mult_switch_mode) begin
            nxt_mult = bus.wdata[`CGCR_BIT_PLL_MULT_HI:`CGCR_BIT_PLL_MULT_LO];
        end
        case (state_ff)
            cgcr_pkg::ST_RUN: begin
                if (mode == cgcr_pkg::MODE_SW_STANDBY) begin
                    nxt_state = cgcr_pkg::ST_STANDBY;
                end
            end
            cgcr_pkg::ST_STANDBY: begin
                // RULE4 deferred switch
                nxt_mult = low_power_ctrl_reg_ff[`CGCR_BIT_PLL_MULT_HI:`CGCR_BIT_PLL_MULT_LO];
                // RULE10 cut takes effect
                nxt_cut = low_power_ctrl_reg_ff[`CGCR_BIT_FEEDBACK_RES_CUT];
                if (mode != cgcr_pkg::MODE_SW_STANDBY) begin
                    nxt_state = cgcr_pkg::ST_WAKE;
                    // RULE12 load wake wait
                    nxt_wait = wake_cycles(STANDBY_WAIT_SEL_I);
                end
            end
            cgcr_pkg::ST_WAKE: begin
                // RULE12 count wake wait
                if (wait_ff == 12'h000) begin
                    nxt_state = cgcr_pkg::ST_RUN;
                end else begin
                    nxt_wait = wait_ff - 12'h001;
                end
            end
            default: begin
                nxt_state = cgcr_pkg::ST_RUN;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            state_ff <= cgcr_pkg::ST_RUN;
            mult_ff <= 2'h0;
            cut_ff <= 1'b0;
            wait_ff <= 12'h000;
        end else begin
            state_ff <= nxt_state;
            mult_ff <= nxt_mult;
            cut_ff <= nxt_cut;
            wait_ff <= nxt_wait;
        end
    end

    // Clock pin, bus master enable, subclock and feedback resistance.
    // The pin shows a half-rate image of the system clock, since a flop cannot copy its own clock.
    always_comb begin
        nxt_phi = !phi_ff;
        nxt_pin = '{level: 1'b1, oe: 1'b1};
        // RULE2 standby pin states
        if (mode == cgcr_pkg::MODE_HW_STANDBY) begin
            nxt_pin.oe = 1'b0;
        end else if (run_mode && !sysclk_out_disable) begin
            // RULE1 clock output
            nxt_pin.level = phi_ff;
        end
        // RULE6 divider enable
        nxt_bm_cnt = bm_cnt_ff + 5'h01;
        nxt_bm_en = (bm_cnt_ff & bm_mask(bm_sel)) == 5'h00;
        nxt_osc_cnt = osc_cnt_ff;
        nxt_subclk = subclk_ff;
        // RULE8 subclock stop
        if (!subclk_gen_stop && OSC_TICK_I) begin
            // RULE13 divide by 128
            nxt_osc_cnt = osc_cnt_ff + 6'h01;
            if (osc_cnt_ff == `CGCR_SUBCLK_HALF_LAST) begin
                nxt_subclk = !subclk_ff;
            end
        end
        // RULE9 feedback follows oscillator
        nxt_fb_on = osc_on && !cut_ff;
    end

    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            phi_ff <= 1'b0;
            pin_ff <= '{level: 1'b1, oe: 1'b1};
            bm_cnt_ff <= 5'h00;
            bm_en_ff <= 1'b1;
            osc_cnt_ff <= 6'h00;
            subclk_ff <= 1'b0;
            fb_on_ff <= 1'b0;
        end else begin
            phi_ff <= nxt_phi;
            pin_ff <= nxt_pin;
            bm_cnt_ff <= nxt_bm_cnt;
            bm_en_ff <= nxt_bm_en;
            osc_cnt_ff <= nxt_osc_cnt;
            subclk_ff <= nxt_subclk;
            fb_on_ff <= nxt_fb_on;
        end
    end

    assign REG_RDATA_O = rdata_ff;
    assign SYSCLK_OUT_O = pin_ff.level;
    assign SYSCLK_OUT_OE_O = pin_ff.oe;
    assign BUS_MASTER_CLK_EN_O = bm_en_ff;
    assign SUBCLK_O = subclk_ff;
    assign FEEDBACK_RES_ON_O = fb_on_ff;
    // RULE11 factor code out
    assign PLL_MULT_O = mult_ff;
    assign CLK_RESUME_O = (state_ff == cgcr_pkg::ST_RUN);
    assign DIRECT_TRANSITION_ON_O = low_power_ctrl_reg_ff[`CGCR_BIT_DIRECT_TRANSITION_ON];
    assign LOW_SPEED_ON_O = low_power_ctrl_reg_ff[`CGCR_BIT_LOW_SPEED_ON];

    default clocking cb @(posedge CORE_CLK_I);
    endclocking
    default disable iff (RST_I);

    a_pin_drives_clock: assert property ( // RULE1
        (run_mode && !sysclk_out_disable) |=> (SYSCLK_OUT_O == $past(phi_ff)) && SYSCLK_OUT_OE_O)
        else $error("Clock pin does not follow the system clock.");

    a_pin_disabled_high: assert property ( // RULE1
        (run_mode && sysclk_out_disable) |=> SYSCLK_OUT_O && SYSCLK_OUT_OE_O)
        else $error("Disabled clock pin is not held high.");

    a_standby_pin_high: assert property ( // RULE2
        stby_mode |=> SYSCLK_OUT_O && SYSCLK_OUT_OE_O)
        else $error("Clock pin not held high in standby.");

    a_hw_standby_float: assert property ( // RULE2
        (mode == cgcr_pkg::MODE_HW_STANDBY) |=> !SYSCLK_OUT_OE_O)
        else $error("Clock pin driven in hardware standby.");

    a_reserved_read_zero: assert property ( // RULE3
        (bus.rd && bus.addr == `CGCR_ADDR_SYS_CLK_CTRL) |=> REG_RDATA_O[6:4] == 3'h0)
        else $error("Reserved clock control bits read nonzero.");

    a_mult_deferred: assert property ( // RULE4
        (!mult_switch_mode && state_ff == cgcr_pkg::ST_RUN) |=> $stable(PLL_MULT_O))
        else $error("Multiplier changed without software standby.");

    a_mult_immediate: assert property ( // RULE5
        (wr_lpw && mult_switch_mode && state_ff == cgcr_pkg::ST_RUN)
        |=> PLL_MULT_O == $past(REG_WDATA_I[1:0]))
        else $error("Multiplier not applied after write.");

    a_bm_full_speed: assert property ( // RULE6
        (bm_sel == 3'h0) |=> BUS_MASTER_CLK_EN_O)
        else $error("Full speed bus master clock skipped a cycle.");

    a_bm_half_speed: assert property ( // RULE6
        (bm_sel == 3'h1) ##1 (bm_sel == 3'h1 && BUS_MASTER_CLK_EN_O) |=> !BUS_MASTER_CLK_EN_O)
        else $error("Divide by two enable not alternating.");

    a_subclk_stopped: assert property ( // RULE8
        subclk_gen_stop |=> $stable(SUBCLK_O))
        else $error("Subclock toggled while stopped.");

    a_subclk_ratio: assert property ( // RULE13
        $changed(SUBCLK_O) |-> ($past(osc_cnt_ff) == 6'h3f) && $past(OSC_TICK_I))
        else $error("Subclock toggled off the divide by 128 point.");

    a_feedback_res: assert property ( // RULE9
        (!cut_ff && osc_on) ##1 !cut_ff |-> FEEDBACK_RES_ON_O)
        else $error("Feedback resistance off while oscillating.");

    a_feedback_cut: assert property ( // RULE10
        cut_ff |=> !FEEDBACK_RES_ON_O)
        else $error("Feedback resistance on while cut.");

    sequence s_standby_exit;
        (state_ff == cgcr_pkg::ST_STANDBY) && (mode != cgcr_pkg::MODE_SW_STANDBY) &&
        (STANDBY_WAIT_SEL_I == 3'h0);
    endsequence

    sequence s_wake_hold;
        !CLK_RESUME_O [*8];
    endsequence

    // Sixteen waiting cycles at setting zero are two runs of eight, then the clock resumes.
    a_wake_wait: assert property ( // RULE12
        s_standby_exit |=> s_wake_hold ##1 s_wake_hold ##1 CLK_RESUME_O)
        else $error("Wake wait length wrong.");

    // Counts the waking cycles up, so every wait setting is checked, not only the shortest.
    logic [12:0] wake_seen_ff, nxt_wake_seen;
    logic [2:0] wake_sel_ff, nxt_wake_sel;

    always_comb begin
        nxt_wake_seen = wake_seen_ff;
        nxt_wake_sel = wake_sel_ff;
        if (state_ff == cgcr_pkg::ST_STANDBY) begin
            nxt_wake_seen = 13'h0000;
            nxt_wake_sel = STANDBY_WAIT_SEL_I;
        end else if (state_ff == cgcr_pkg::ST_WAKE) begin
            nxt_wake_seen = wake_seen_ff + 13'h0001;
        end
    end

    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            wake_seen_ff <= 13'h0000;
            wake_sel_ff <= 3'h0;
        end else begin
            wake_seen_ff <= nxt_wake_seen;
            wake_sel_ff <= nxt_wake_sel;
        end
    end

    a_wake_length: assert property ( // RULE12
        (state_ff == cgcr_pkg::ST_WAKE) ##1 (state_ff == cgcr_pkg::ST_RUN)
        |-> wake_seen_ff == (13'(`CGCR_WAIT_UNIT_CYC) << wake_sel_ff))
        else $error("Wake wait does not match the wait setting.");

    a_power_bits_stored: assert property ( // RULE14
        wr_lpw |=> DIRECT_TRANSITION_ON_O == $past(REG_WDATA_I[7]) &&
                   LOW_SPEED_ON_O == $past(REG_WDATA_I[6]))
        else $error("Power control bits not stored.");

endmodule // cgcr_ctrl

// ### bench/test_clock_generator_control_regs.sv
// Self-checking testbench of the clock generator control register block.
`timescale 1ns/1ps
`include "cgcr_defs.svh"

module test_clock_generator_control_regs;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [3:0] op_mode = 4'h0;
    logic [2:0] wait_sel = 3'h0;
    logic osc_tick = 1'b0;
    logic [7:0] rdata;
    logic [1:0] mult;
    logic pin, pin_oe, bm_en, subclk, fb_on, resume, dt_on, ls_on;
    int err_total = 0;
    int tests_run = 0;

    always #12.5 clk = ~clk;
    // Ticks on every second cycle, so a subclock half period spans 128 core cycles.
    always @(posedge clk) osc_tick <= ~osc_tick;

    cgcr_ctrl u_dut (
        .CORE_CLK_I(clk), .RST_I(rst), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
        .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata), .OP_MODE_I(op_mode),
        .STANDBY_WAIT_SEL_I(wait_sel), .OSC_TICK_I(osc_tick), .SYSCLK_OUT_O(pin),
        .SYSCLK_OUT_OE_O(pin_oe), .BUS_MASTER_CLK_EN_O(bm_en), .SUBCLK_O(subclk),
        .FEEDBACK_RES_ON_O(fb_on), .PLL_MULT_O(mult), .CLK_RESUME_O(resume),
        .DIRECT_TRANSITION_ON_O(dt_on), .LOW_SPEED_ON_O(ls_on)
    );

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask

    task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic set_mode(input logic [3:0] m);
        @(posedge clk);
        op_mode <= m;
    endtask

    task automatic wait_resume(output int n);
        n = 0;
        while (resume !== 1'b1 && n < 2000) begin
            cycles(1);
            n++;
        end
    endtask

    task automatic pin_check(input int m, input logic dis);
        logic p;
        set_mode(m[3:0]);
        cycles(3);
        p = pin;
        cycles(1);
        if (m == 8)
            chk({7'h00, pin_oe}, 8'h00);
        else if (m >= 5 || dis)
            chk({6'h00, pin_oe, pin & p}, 8'h03);
        else
            chk({6'h00, pin_oe, pin ^ p}, 8'h03);
    endtask

    task automatic sub_gap(output int n);
        logic p;
        int k;
        p = subclk;
        for (k = 0; k < 300 && subclk === p; k++) cycles(1);
        p = subclk;
        n = 0;
        while (subclk === p && n < 300) begin
            cycles(1);
            n++;
        end
    endtask

    initial begin
        // A full run needs well under 20,000 cycles.
        #1000000;
        err_total++;
        conclude();
    end

    initial begin
        logic [7:0] d;
        int n;
        int i;
        int e;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        reg_rd(`CGCR_ADDR_SYS_CLK_CTRL, d);
        chk(d, 8'h00);
        reg_rd(`CGCR_ADDR_LOW_PWR_CTRL, d);
        chk(d, 8'h00);
        chk({4'h0, mult, pin_oe, resume}, 8'h03);
        reg_wr(`CGCR_ADDR_SYS_CLK_CTRL, 8'h7d);
        reg_rd(`CGCR_ADDR_SYS_CLK_CTRL, d);
        chk(d, 8'h0d);
        reg_wr(4'h5, 8'hff);
        reg_rd(4'h5, d);
        chk(d, 8'h00);
        // divider codes; only the legal ones are ever written.
        for (i = 0; i < 6; i++) begin
            reg_wr(`CGCR_ADDR_SYS_CLK_CTRL, 8'h08 | i[7:0]);
            reg_rd(`CGCR_ADDR_SYS_CLK_CTRL, d);
            chk(d, 8'h08 | i[7:0]);
            cycles(8);
            n = 0;
            repeat (64) begin
                cycles(1);
                if (bm_en === 1'b1) n++;
            end
            e = 64 >> i;
            chk(n[7:0], e[7:0]);
        end
        for (i = 2; i >= 0; i--) begin
            reg_wr(`CGCR_ADDR_LOW_PWR_CTRL, i[7:0]);
            chk({6'h00, mult}, i[7:0]);
        end
        reg_wr(`CGCR_ADDR_LOW_PWR_CTRL, 8'hc0);
        chk({6'h00, dt_on, ls_on}, 8'h03);
        reg_rd(`CGCR_ADDR_LOW_PWR_CTRL, d);
        chk(d, 8'hc0);
        reg_wr(`CGCR_ADDR_LOW_PWR_CTRL, 8'h00);
        chk({6'h00, dt_on, ls_on}, 8'h00);
        for (i = 0; i < 9; i++) pin_check(i, 1'b0);
        reg_wr(`CGCR_ADDR_SYS_CLK_CTRL, 8'h88);
        for (i = 0; i < 5; i++) pin_check(i, 1'b1);
        set_mode(4'h0);
        wait_resume(n);
        chk({7'h00, resume}, 8'h01);
        // deferred factor and cut through standby.
        reg_wr(`CGCR_ADDR_SYS_CLK_CTRL, 8'h00);
        @(posedge clk) wait_sel <= 3'h1;
        reg_wr(`CGCR_ADDR_LOW_PWR_CTRL, 8'h09);
        cycles(4);
        chk({5'h00, mult, fb_on}, 8'h01);
        set_mode(4'h5);
        cycles(3);
        chk({5'h00, mult, fb_on}, 8'h02);
        chk({7'h00, resume}, 8'h00);
        set_mode(4'h0);
        wait_resume(n);
        // One edge to see the mode leave standby, then the whole wake wait.
        e = 1 + (`CGCR_WAIT_UNIT_CYC << 1);
        chk(n[7:0], e[7:0]);
        cycles(2);
        chk({5'h00, mult, fb_on}, 8'h02);
        // resistance follows the oscillator once the cut is cleared.
        @(posedge clk) wait_sel <= 3'h0;
        reg_wr(`CGCR_ADDR_LOW_PWR_CTRL, 8'h01);
        set_mode(4'h5);
        cycles(3);
        chk({7'h00, fb_on}, 8'h00);
        set_mode(4'h0);
        wait_resume(n);
        e = 1 + `CGCR_WAIT_UNIT_CYC;
        chk(n[7:0], e[7:0]);
        cycles(2);
        chk({7'h00, fb_on}, 8'h01);
        sub_gap(n);
        chk(n[7:0], 8'h80);
        reg_wr(`CGCR_ADDR_LOW_PWR_CTRL, 8'h11);
        cycles(4);
        sub_gap(n);
        chk({7'h00, n == 300}, 8'h01);
        conclude();
    end
endmodule // test_clock_generator_control_regs
